//--- hdl/cds_edge_det.sv
// Samples the input source on generator ticks and flags its rising edge
`timescale 1ns/100ps
module cds_edge_det (
   input  wire logic clk_i,    // System clock
   input  wire logic rst_n_i,  // Async reset, active low
   input  wire logic tick_i,   // Generator tick
   input  wire logic wave_i,   // Input source level
   output logic      level_o,  // Sampled level
   output logic      rise_o    // One-tick rising edge
);

   logic prev_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= 1'b0;
      end else if (tick_i) begin
         prev_q <= wave_i;
      end
   end

   always_comb begin
      level_o = prev_q;
      rise_o  = tick_i & wave_i & ~prev_q;
   end

endmodule : cds_edge_det

//--- hdl/cds_pkg.sv
// Package: register map, field positions and timing of the drive block
package cds_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [7:0] WCTL0_OFS = 8'h00;
   localparam logic [7:0] SDCTL_OFS = 8'h01;
   localparam logic [7:0] IRQST_OFS = 8'h02;
   localparam logic [7:0] IRQMK_OFS = 8'h03;
   localparam logic [7:0] STATE_OFS = 8'h04;

   // waveform_control_0 fields
   localparam int EN_BIT   = 7;
   localparam int OEB_BIT  = 6;
   localparam int OEA_BIT  = 5;
   localparam int POLB_BIT = 4;
   localparam int POLA_BIT = 3;
   localparam int CS_BIT   = 0;
   localparam logic [7:0] WCTL0_RST  = 8'h00;
   localparam logic [7:0] WCTL0_MASK = 8'hF9;

   // shutdown_control fields
   localparam int ASE_BIT   = 7;
   localparam int ARSEN_BIT = 6;
   localparam int LVLB_BIT  = 5;
   localparam int LVLA_BIT  = 4;
   localparam int SRC1_BIT  = 1;
   localparam int SRC0_BIT  = 0;
   localparam logic [7:0] SDCTL_RST = 8'h00;

   // Interrupt status and mask fields
   localparam int EV_SHDN_BIT = 0;
   localparam int EV_RUN_BIT  = 1;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // Slow generator clock: one tick per this many system cycles
   localparam logic [3:0] SLOW_DIV = 4'h8;

   typedef enum logic [3:0] {
      ST_OFF  = 4'h1,
      ST_SHDN = 4'h2,
      ST_WAIT = 4'h4,
      ST_RUN  = 4'h8
   } cds_state_t;

endpackage : cds_pkg

//--- hdl/cds_tick_gen.sv
// Generator clock tick: every cycle or divided, chosen by software
`timescale 1ns/100ps
module cds_tick_gen
   import cds_pkg::*;
(
   input  wire logic clk_i,    // System clock
   input  wire logic rst_n_i,  // Async reset, active low
   input  wire logic fast_i,   // 1: tick every cycle
   output logic      tick_o    // Generator tick
);

   logic [3:0] cnt_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 4'h0;
      end else if (cnt_q == SLOW_DIV - 4'h1) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_comb begin
      tick_o = fast_i | (cnt_q == 4'h0);
   end

endmodule : cds_tick_gen

//--- hdl/cds_top.sv
// Complementary drive: shutdown override, restart and control registers
//
// Summary of operation
// - Shutdown drives A and B to override levels
// - Override bit value is the pin level
// - Polarity never touches override levels
// - Auto-restart bit picks restart method
// - Software restart resumes on next rising edge
// - Clear succeeds only with selected inputs low
// - Auto-restart clears bit, resumes on rising edge
// - Control 0 bit 6 gates output B
// - Control 0 bit 5 gates output A
// - Bits 4/3 invert outputs B/A
// - Control 0 bits 2:1 read zero
// - Writing shutdown-active 1 forces shutdown
// - Selected inputs high force override, level sensitive
// - Module disabled leaves pins undriven
`timescale 1ns/100ps
module cds_top
   import cds_pkg::*;
(
   input  wire logic                  SYS_CLK_I,    // 125 MHz clock
   input  wire logic                  RST_N_I,      // Async reset
   input  wire logic [cds_pkg::ADDR_W-1:0] ADDR_I,  // Register address
   input  wire logic [cds_pkg::DATA_W-1:0] WDATA_I, // Write data
   input  wire logic                  WR_I,         // Write strobe
   input  wire logic                  RD_I,         // Read strobe
   output logic [cds_pkg::DATA_W-1:0] RDATA_O,      // Read data
   input  wire logic                  WAVE_I,       // Input source
   input  wire logic [1:0]            SHDN_I,       // Shutdown inputs
   output logic                       DRV_A_O,      // Output A level
   output logic                       DRV_A_OE_N_O, // A enable, low
   output logic                       DRV_B_O,      // Output B level
   output logic                       DRV_B_OE_N_O, // B enable, low
   output logic                       IRQ_O         // Interrupt
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0] wctl0_q;
   logic       ase_q;
   logic       ase_d;
   logic       arsen_q;
   logic       lvl_a_q;
   logic       lvl_b_q;
   logic [1:0] src_sel_q;
   logic [1:0] irq_st_q;
   logic [1:0] irq_st_d;
   logic [1:0] irq_mk_q;
   logic [7:0] rdata_q;
   logic       drv_a_q;
   logic       drv_b_q;
   logic       oe_a_n_q;
   logic       oe_b_n_q;
   logic       irq_q;
   logic       hold_ovr_q;
   cds_state_t st_q;
   cds_state_t st_d;

   logic       tick;
   logic       wave_lvl;
   logic       wave_rise;
   logic       ext_fault;
   logic       shdn;
   logic       wr_wctl0;
   logic       wr_sdctl;
   logic       wr_irqst;
   logic       wr_irqmk;
   logic       ev_shdn;
   logic       ev_run;
   logic       en;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////
   // Helpers

   cds_tick_gen u_tick (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .fast_i  (wctl0_q[CS_BIT]),
      .tick_o  (tick)
   );

   cds_edge_det u_edge (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .tick_i  (tick),
      .wave_i  (WAVE_I),
      .level_o (wave_lvl),
      .rise_o  (wave_rise)
   );

   ////////////////////////////////////////////////////////////////////
   // Decode

   always_comb begin
      wr_wctl0 = WR_I & hit(ADDR_I, WCTL0_OFS);
      wr_sdctl = WR_I & hit(ADDR_I, SDCTL_OFS);
      wr_irqst = WR_I & hit(ADDR_I, IRQST_OFS);
      wr_irqmk = WR_I & hit(ADDR_I, IRQMK_OFS);
   end

   always_comb begin
      en        = wctl0_q[EN_BIT];
      // Inputs are levels: a held fault keeps shutdown asserted
      ext_fault = |(SHDN_I & src_sel_q);
      shdn      = ase_q | ext_fault;
   end

   ////////////////////////////////////////////////////////////////////
   // Control register 0

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wctl0_q <= WCTL0_RST;
      end else if (wr_wctl0) begin
         wctl0_q <= WDATA_I & WCTL0_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Shutdown control

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         arsen_q   <= SDCTL_RST[ARSEN_BIT];
         lvl_a_q   <= SDCTL_RST[LVLA_BIT];
         lvl_b_q   <= SDCTL_RST[LVLB_BIT];
         src_sel_q <= SDCTL_RST[SRC1_BIT:SRC0_BIT];
      end else if (wr_sdctl) begin
         arsen_q   <= WDATA_I[ARSEN_BIT];
         lvl_a_q   <= WDATA_I[LVLA_BIT];
         lvl_b_q   <= WDATA_I[LVLB_BIT];
         src_sel_q <= WDATA_I[SRC1_BIT:SRC0_BIT];
      end
   end

   // A fault always wins over any clear, software or automatic
   always_comb begin
      ase_d = ase_q;
      if (ext_fault) begin
         ase_d = 1'b1;
      end else if (wr_sdctl && WDATA_I[ASE_BIT]) begin
         ase_d = 1'b1;
      end else if (arsen_q) begin
         ase_d = 1'b0;
      end else if (wr_sdctl) begin
         ase_d = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ase_q <= SDCTL_RST[ASE_BIT];
      end else begin
         ase_q <= ase_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Run state

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_OFF: begin
            if (en && shdn) begin
               st_d = ST_SHDN;
            end else if (en) begin
               st_d = ST_WAIT;
            end
         end
         ST_SHDN: begin
            if (!en) begin
               st_d = ST_OFF;
            end else if (!shdn) begin
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!en) begin
               st_d = ST_OFF;
            end else if (shdn) begin
               st_d = ST_SHDN;
            end else if (wave_rise) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!en) begin
               st_d = ST_OFF;
            end else if (shdn) begin
               st_d = ST_SHDN;
            end
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q <= ST_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   // After a shutdown the override stays until the restart edge
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         hold_ovr_q <= 1'b0;
      end else if (st_d == ST_SHDN) begin
         hold_ovr_q <= 1'b1;
      end else if (st_d == ST_RUN || st_d == ST_OFF) begin
         hold_ovr_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output drive

   // Dead band is not part of this block: B is the plain complement
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         drv_a_q <= 1'b0;
         drv_b_q <= 1'b0;
      end else if (!en) begin
         drv_a_q <= 1'b0;
         drv_b_q <= 1'b0;
      end else if (st_d == ST_SHDN || (hold_ovr_q && st_d == ST_WAIT)) begin
         drv_a_q <= lvl_a_q;
         drv_b_q <= lvl_b_q;
      end else if (st_d == ST_RUN) begin
         drv_a_q <= wave_lvl ^ wctl0_q[POLA_BIT];
         drv_b_q <= ~wave_lvl ^ wctl0_q[POLB_BIT];
      end else begin
         drv_a_q <= 1'b0;
         drv_b_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         oe_a_n_q <= 1'b1;
         oe_b_n_q <= 1'b1;
      end else begin
         oe_a_n_q <= ~(en & wctl0_q[OEA_BIT]);
         oe_b_n_q <= ~(en & wctl0_q[OEB_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupts

   always_comb begin
      ev_shdn  = en & shdn & (st_q != ST_SHDN);
      ev_run   = (st_q == ST_WAIT) & (st_d == ST_RUN);
      // Set beats a simultaneous write-one-to-clear
      irq_st_d = irq_st_q;
      if (wr_irqst) begin
         irq_st_d = irq_st_q & ~WDATA_I[1:0];
      end
      irq_st_d[EV_SHDN_BIT] = irq_st_d[EV_SHDN_BIT] | ev_shdn;
      irq_st_d[EV_RUN_BIT]  = irq_st_d[EV_RUN_BIT] | ev_run;
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_st_q <= IRQ_RST;
      end else begin
         irq_st_q <= irq_st_d;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_mk_q <= IRQ_RST;
      end else if (wr_irqmk) begin
         irq_mk_q <= WDATA_I[1:0];
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_st_d & irq_mk_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_q <= 8'h00;
      end else if (!RD_I) begin
         rdata_q <= 8'h00;
      end else begin
         case (ADDR_I)
            WCTL0_OFS: begin
               rdata_q <= wctl0_q;
            end
            SDCTL_OFS: begin
               rdata_q <= {ase_q, arsen_q, lvl_b_q, lvl_a_q,
                           2'h0, src_sel_q};
            end
            IRQST_OFS: begin
               rdata_q <= {6'h00, irq_st_q};
            end
            IRQMK_OFS: begin
               rdata_q <= {6'h00, irq_mk_q};
            end
            STATE_OFS: begin
               rdata_q <= {st_q, ext_fault, wave_lvl, SHDN_I};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   always_comb begin
      RDATA_O      = rdata_q;
      DRV_A_O      = drv_a_q;
      DRV_B_O      = drv_b_q;
      DRV_A_OE_N_O = oe_a_n_q;
      DRV_B_OE_N_O = oe_b_n_q;
      IRQ_O        = irq_q;
   end

endmodule : cds_top

//--- test/cds_assertions.sv
// Checker: port-level assertions of the drive block
`timescale 1ns/100ps
module cds_chk
   import cds_pkg::*;
(
   input wire logic                        SYS_CLK_I,    // Clock
   input wire logic                        RST_N_I,      // Reset
   input wire logic [cds_pkg::ADDR_W-1:0]  ADDR_I,       // Address
   input wire logic [cds_pkg::DATA_W-1:0]  WDATA_I,      // Write data
   input wire logic                        WR_I,         // Write strobe
   input wire logic                        RD_I,         // Read strobe
   input wire logic [cds_pkg::DATA_W-1:0]  RDATA_O,      // Read data
   input wire logic                        WAVE_I,       // Input source
   input wire logic [1:0]                  SHDN_I,       // Shutdown inputs
   input wire logic                        DRV_A_O,      // Output A
   input wire logic                        DRV_A_OE_N_O, // A enable
   input wire logic                        DRV_B_O,      // Output B
   input wire logic                        DRV_B_OE_N_O, // B enable
   input wire logic                        IRQ_O         // Interrupt
);
   // Shadows of the written controls; hardware clears of shutdown-active
   // are not tracked, so only software-owned fields are used
   logic [7:0] ctl_q;
   logic [7:0] sd_q;
   logic       en;
   logic       flt;
   logic       lvl_ok;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctl_q <= 8'h00;
         sd_q  <= 8'h00;
      end else if (WR_I) begin
         if (ADDR_I == WCTL0_OFS) ctl_q <= WDATA_I;
         if (ADDR_I == SDCTL_OFS) sd_q <= WDATA_I;
      end
   end

   assign en     = ctl_q[EN_BIT];
   assign flt    = |(SHDN_I & sd_q[SRC1_BIT:SRC0_BIT]);
   assign lvl_ok = DRV_A_O == sd_q[LVLA_BIT] && DRV_B_O == sd_q[LVLB_BIT];

   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   ////////////////////////////////////////////////////////////////////////
   sequence s_fault;
      (en && flt) [*3];
   endsequence
   sequence s_hold;
      (en && flt) ##1 (en && !WAVE_I) [*5];
   endsequence
   sequence s_rd;
      RD_I ##1 !RD_I;
   endsequence

   property p_fault_ovr;
      s_fault |-> lvl_ok;
   endproperty
   property p_ase_write;
      WR_I && ADDR_I == SDCTL_OFS && WDATA_I[ASE_BIT] && en |-> ##[1:3] lvl_ok;
   endproperty
   property p_hold_edge;
      s_hold |-> lvl_ok;
   endproperty
   property p_dis;
      (!en) [*2] |-> DRV_A_OE_N_O && DRV_B_OE_N_O && !DRV_A_O && !DRV_B_O;
   endproperty
   property p_oea_off;
      (en && !ctl_q[OEA_BIT]) [*2] |-> DRV_A_OE_N_O;
   endproperty
   property p_oeb_off;
      (en && !ctl_q[OEB_BIT]) [*2] |-> DRV_B_OE_N_O;
   endproperty
   property p_oe_on;
      (en && ctl_q[OEA_BIT] && ctl_q[OEB_BIT]) [*2]
         |-> !DRV_A_OE_N_O && !DRV_B_OE_N_O;
   endproperty
   property p_rd_rsvd;
      RD_I && ADDR_I == WCTL0_OFS |=> RDATA_O[2:1] == 2'h0;
   endproperty
   property p_rd_stand;
      s_rd |=> RDATA_O == 8'h00;
   endproperty

   a_fault_ovr: assert property (p_fault_ovr)
      else $error("override levels missing during fault");
   a_ase_write: assert property (p_ase_write)
      else $error("shutdown write did not force levels");
   a_hold_edge: assert property (p_hold_edge)
      else $error("resumed without a rising input edge");
   a_dis: assert property (p_dis)
      else $error("pins driven while disabled");
   a_oea_off: assert property (p_oea_off)
      else $error("output A enabled while gated off");
   a_oeb_off: assert property (p_oeb_off)
      else $error("output B enabled while gated off");
   a_oe_on: assert property (p_oe_on)
      else $error("outputs not enabled");
   a_rd_rsvd: assert property (p_rd_rsvd)
      else $error("reserved bits read nonzero");
   a_rd_stand: assert property (p_rd_stand)
      else $error("read data stood too long");
endmodule : cds_chk

bind cds_top cds_chk u_chk (.SYS_CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I,
   .RD_I, .RDATA_O, .WAVE_I, .SHDN_I, .DRV_A_O, .DRV_A_OE_N_O, .DRV_B_O,
   .DRV_B_OE_N_O, .IRQ_O);

//--- test/cds_switch_model.sv
// Partner: power switch stage fed by the two drive outputs
`timescale 1ns/100ps
module cds_switch_model (
   input  wire logic clk_i,    // System clock
   input  wire logic drv_a_i,  // Level A
   input  wire logic oe_n_a_i, // Enable A, low
   input  wire logic drv_b_i,  // Level B
   input  wire logic oe_n_b_i, // Enable B, low
   output logic      pin_a_o,  // Switch A state
   output logic      pin_b_o   // Switch B state
);
   // An undriven gate floats: show the inverse of the last level so a
   // stale value never passes for a driven one
   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
   end
   always @(posedge clk_i) begin
      pin_a_o <= oe_n_a_i ? ~pin_a_o : drv_a_i;
      pin_b_o <= oe_n_b_i ? ~pin_b_o : drv_b_i;
   end
endmodule : cds_switch_model

//--- test/tb_top.sv
// Testbench: register, shutdown and restart scenarios of the drive block
`timescale 1ns/100ps
module tb_top;
   import cds_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, wave = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, seed = 8'h11, ctl, lv;
   logic [1:0] shdn = 2'h0;
   logic       drv_a, drv_b, oen_a, oen_b, irq, pin_a, pin_b;
   int         num_errors = 0, comparisons = 0;

   always #4 clk = ~clk;

   cds_top uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .WAVE_I(wave),
      .SHDN_I(shdn), .DRV_A_O(drv_a), .DRV_A_OE_N_O(oen_a), .DRV_B_O(drv_b),
      .DRV_B_OE_N_O(oen_b), .IRQ_O(irq));
   cds_switch_model u_sw (.clk_i(clk), .drv_a_i(drv_a), .oe_n_a_i(oen_a),
      .drv_b_i(drv_b), .oe_n_b_i(oen_b), .pin_a_o(pin_a), .pin_b_o(pin_b));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // Running levels {A, B} for a wave level under control 0 settings
   function automatic logic [1:0] run_lvl(input logic w, input logic [7:0] c);
      return {w ^ c[POLA_BIT], ~w ^ c[POLB_BIT]};
   endfunction : run_lvl
   task automatic cmp(input string what, input logic [7:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      cmp("register", exp, rdata);
      @(posedge clk);
   endtask : rd_chk
   task automatic chk_out(input logic [1:0] exp);
      cmp("pins", {6'h00, exp}, {6'h00, pin_a, pin_b});
   endtask : chk_out
   task automatic stop_test;
      $display("comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(20000);
      num_errors++;
      stop_test();
   end

   initial begin
      cyc(12);
      rst_n <= 1'b1;
      rd_chk(WCTL0_OFS, WCTL0_RST);
      rd_chk(SDCTL_OFS, SDCTL_RST);
      rd_chk(8'h7F, 8'h00);
      seed = lfsr(seed);
      wr_reg(WCTL0_OFS, seed | 8'h06);
      rd_chk(WCTL0_OFS, (seed | 8'h06) & WCTL0_MASK);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         ctl = 8'hE1 | {3'h0, i[1:0], 3'h0};
         lv = {2'h0, seed[1:0], 4'h3};
         wr_reg(SDCTL_OFS, lv);
         wr_reg(WCTL0_OFS, ctl);
         wave <= 1'b0;
         cyc(12);
         wave <= 1'b1;
         cyc(12);
         chk_out(run_lvl(1'b1, ctl));
         wave <= 1'b0;
         cyc(12);
         chk_out(run_lvl(1'b0, ctl));
         shdn <= i[0] ? 2'h1 : 2'h2;
         cyc(12);
         chk_out({lv[LVLA_BIT], lv[LVLB_BIT]});
         wr_reg(SDCTL_OFS, lv);
         rd_chk(SDCTL_OFS, lv | 8'h80);
         shdn <= 2'h0;
         wr_reg(SDCTL_OFS, lv);
         rd_chk(SDCTL_OFS, lv);
         cyc(12);
         chk_out({lv[LVLA_BIT], lv[LVLB_BIT]});
         wave <= 1'b1;
         cyc(12);
         chk_out(run_lvl(1'b1, ctl));
      end
      rd_chk(IRQST_OFS, 8'h03);
      rd_chk(STATE_OFS, 8'h84);
      wr_reg(IRQMK_OFS, 8'h01);
      cyc(2);
      cmp("irq", 8'h01, {7'h00, irq});
      wr_reg(IRQMK_OFS, 8'h00);
      cyc(2);
      cmp("irq", 8'h00, {7'h00, irq});
      wr_reg(IRQST_OFS, 8'h03);
      rd_chk(IRQST_OFS, 8'h00);
      wr_reg(IRQMK_OFS, 8'h03);
      cyc(2);
      cmp("irq", 8'h00, {7'h00, irq});
      lv = 8'h51;
      wr_reg(SDCTL_OFS, lv);
      wave <= 1'b0;
      shdn <= 2'h1;
      cyc(12);
      chk_out(2'b10);
      shdn <= 2'h0;
      cyc(12);
      rd_chk(SDCTL_OFS, lv);
      chk_out(2'b10);
      wave <= 1'b1;
      cyc(12);
      chk_out(run_lvl(1'b1, ctl));
      // Override A high, B low: unlike the running levels 01 just before
      wr_reg(SDCTL_OFS, 8'h90);
      cyc(4);
      chk_out(2'b10);
      wr_reg(SDCTL_OFS, 8'h10);
      wr_reg(WCTL0_OFS, 8'hE8);
      wave <= 1'b0;
      cyc(24);
      chk_out(2'b10);
      wave <= 1'b1;
      cyc(24);
      chk_out(run_lvl(1'b1, 8'hE8));
      wr_reg(WCTL0_OFS, 8'hA1);
      cyc(3);
      cmp("enables", 8'h01, {6'h00, oen_a, oen_b});
      wr_reg(WCTL0_OFS, 8'h61);
      cyc(3);
      cmp("disabled", 8'h0C, {4'h0, oen_a, oen_b, drv_a, drv_b});
      stop_test();
   end
endmodule : tb_top
